// File: bench/tcr_chip_model.sv
`timescale 1ns/1ps
module tcr_chip_model #(
  parameter logic [3:0] BUILD_ID = 4'h9  // Arbitrary build value
)
(
  input wire logic hclk,
  input wire logic pll_vco_power_off,
  input wire logic pll_hard_reset_n,
  input wire logic wfi,
  input wire logic [1:0] comms,
  output logic chip_pll_locked,
  output logic board_pll_locked,
  output logic idle_standby_flag,
  output logic [1:0] comms_flags,
  output logic [3:0] logic_build_id
);
  // No lock while the VCO is off or the PLL is held in reset
  always_ff @(posedge hclk) begin
    chip_pll_locked <= pll_hard_reset_n & ~pll_vco_power_off;
  end
  assign board_pll_locked = 1'b1;
  assign idle_standby_flag = wfi;
  assign comms_flags = comms;
  assign logic_build_id = BUILD_ID;
endmodule

// File: bench/tcr_regs_test.sv
`timescale 1ns/1ps
`include "tcr_consts.svh"
module tcr_regs_test;
  // Arbitrary type code
  localparam logic [7:0] TYPE_CODE = 8'h3C;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic wfi = 1'b0;
  logic [1:0] comms = 2'h0;
  logic hrdy;
  logic hrsp;
  logic [31:0] hrdata;
  logic cfg_up;
  logic pll_up;
  logic [12:0] pins;
  logic [31:0] plls;
  logic [1:0] cf;
  logic cl;
  logic bl;
  logic idl;
  logic [3:0] bid;
  int n_mismatch = 0;
  int samples_checked = 0;

  tcr_regs #(.PROC_TYPE_CODE(TYPE_CODE)) u_tcr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hrsp), .hrdata(hrdata), .clock_test_select(pins[12:11]),
    .pll_vco_power_off(pins[10]), .pll_bypass_ctl(pins[9]),
    .vector_unit_reset_n(pins[8]), .nondebug_reset_n(pins[7]), .bus_if_reset_n(pins[6]),
    .pll_hard_reset_n(pins[5]), .trace_trigger_reset_n(pins[4]),
    .debug_bus_reset_n(pins[3]), .fast_irq_unmaskable_cfg(pins[2]),
    .syscop_disable(pins[1]), .high_vector_select(pins[0]), .cfg_update(cfg_up),
    .bus_clock_divider(plls[31:24]), .core_clock_divider(plls[23:16]),
    .feedback_multiplier(plls[15:4]), .reference_divider(plls[3:0]), .pll_update(pll_up),
    .comms_receive_flag(cf[1]), .comms_transmit_flag(cf[0]), .idle_standby_flag(idl),
    .chip_pll_locked(cl), .board_pll_locked(bl), .logic_build_id(bid));

  tcr_chip_model u_tcr_chip_model (
    .hclk(hclk), .pll_vco_power_off(pins[10]), .pll_hard_reset_n(pins[5]), .wfi(wfi),
    .comms(comms), .chip_pll_locked(cl), .board_pll_locked(bl),
    .idle_standby_flag(idl), .comms_flags(cf), .logic_build_id(bid));

  initial begin
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ready and read data are taken at the rising edge, before the slave updates them
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hrdy !== 1'b1) begin
      @(posedge hclk);
    end
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) begin
      @(posedge hclk);
    end
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(nm, r, exp);
  endtask

  task automatic t_reset;
    rdc("ctrl", `TCR_CTRL_OFS, {19'h0, `TCR_CTRL_RESET});
    chk("pins", {19'h0, pins}, {19'h0, `TCR_CTRL_RESET});
    rdc("pll", `TCR_PLL_OFS, `TCR_PLL_RESET);
    chk("dividers", plls, `TCR_PLL_RESET);
    rdc("id", `TCR_ID_OFS, {TYPE_CODE, 6'h0, 3'h4, 3'h4, 12'h000});
    $display("reset values done");
  endtask

  task automatic t_status;
    wfi <= 1'b1;
    comms <= 2'h2;
    repeat (8) @(posedge hclk);
    rdc("status", `TCR_STAT_OFS, 32'h0000_00B9);
    wr(`TCR_STAT_OFS, 32'hFFFF_FFFF);
    chk("resp", {31'h0, hrsp}, 32'h0000_0000);
    rdc("status", `TCR_STAT_OFS, 32'h0000_00B9);
    wr(`TCR_LOCK_OFS, `TCR_UNLOCK_KEY);
    wr(`TCR_CTRL_OFS, 32'h0000_0400);
    wfi <= 1'b0;
    comms <= 2'h1;
    repeat (8) @(posedge hclk);
    rdc("status", `TCR_STAT_OFS, 32'h0000_0049);
    wfi <= 1'b1;
    @(posedge hclk);
    wfi <= 1'b0;
    repeat (8) @(posedge hclk);
    rdc("blip", `TCR_STAT_OFS, 32'h0000_0049);
    $display("status done");
  endtask

  task automatic t_ctrl;
    wr(`TCR_LOCK_OFS, 32'h0000_A060);
    wr(`TCR_CTRL_OFS, 32'h0000_1FFF);
    @(negedge hclk);
    chk("pulse", {31'h0, cfg_up}, 32'h0000_0000);
    rdc("ctrl", `TCR_CTRL_OFS, 32'h0000_0400);
    rdc("lock", `TCR_LOCK_OFS, 32'h0001_A060);
    wr(`TCR_LOCK_OFS, `TCR_UNLOCK_KEY);
    wr(`TCR_CTRL_OFS, 32'hFFFF_FFFF);
    @(negedge hclk);
    chk("pulse", {31'h0, cfg_up}, 32'h0000_0001);
    rdc("ctrl", `TCR_CTRL_OFS, 32'h0000_1FFF);
    for (int i = 0; i < 13; i++) begin
      wr(`TCR_CTRL_OFS, 32'h0000_0001 << i);
      @(negedge hclk);
      chk("pin", {19'h0, pins}, 32'h0000_0001 << i);
    end
    $display("control done");
  endtask

  task automatic t_pll;
    wr(`TCR_PLL_OFS, 32'h1234_5678);
    @(negedge hclk);
    chk("pulse", {31'h0, pll_up}, 32'h0000_0001);
    chk("dividers", plls, 32'h1234_5678);
    wr(`TCR_LOCK_OFS, 32'h0000_0000);
    wr(`TCR_PLL_OFS, 32'h0000_0000);
    rdc("pll", `TCR_PLL_OFS, 32'h1234_5678);
    wr(`TCR_ID_OFS, 32'h0000_0000);
    rdc("id", `TCR_ID_OFS, {TYPE_CODE, 6'h0, 3'h4, 3'h4, 12'h000});
    wr(32'h1000_0080, 32'hFFFF_FFFF);
    rdc("hole", 32'h1000_0080, 32'h0000_0000);
    $display("pll and id done");
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_status();
    t_ctrl();
    t_pll();
    give_verdict();
  end
endmodule

// File: include/tcr_bus_if.sv
`timescale 1ns/1ps
interface tcr_bus_if;
  logic wr;
  logic [31:0] wr_addr;
  logic [31:0] wdata;
  logic [31:0] rd_addr;
  logic [31:0] rdata;

  modport slave (output wr, output wr_addr, output wdata, output rd_addr, input rdata);
  modport regs (input wr, input wr_addr, input wdata, input rd_addr, output rdata);
endinterface

// File: include/tcr_consts.svh
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH

// Byte addresses of the register words
`define TCR_CTRL_OFS 32'h1000_0074
`define TCR_STAT_OFS 32'h1000_0078
`define TCR_PLL_OFS 32'h1000_007C
`define TCR_ID_OFS 32'h1000_0084
`define TCR_LOCK_OFS 32'h1000_00C0

// Control word: live bits 12:0, bits 31:13 read as zero
`define TCR_CTRL_W 13
`define TCR_CTRL_RESET 13'h11F8
`define TCR_PLL_RESET 32'h0B01_01D0
`define TCR_UNLOCK_KEY 32'h0000_A05F

// Status word: live bits 7:0
`define TCR_STAT_W 8
`define TCR_SYNC_W 9

// Identification word field positions
`define TCR_ID_TYPE_LSB 24
`define TCR_ID_DCACHE_LSB 15
`define TCR_ID_ICACHE_LSB 12
`define TCR_CACHE_32K 3'h4

`endif

// File: include/tcr_pkg.sv
package tcr_pkg;

  typedef struct packed {
    logic [1:0] clock_test_select;
    logic pll_vco_power_off;
    logic pll_bypass_ctl;
    logic vector_unit_reset_n;
    logic nondebug_reset_n;
    logic bus_if_reset_n;
    logic pll_hard_reset_n;
    logic trace_trigger_reset_n;
    logic debug_bus_reset_n;
    logic fast_irq_unmaskable_cfg;
    logic syscop_disable;
    logic high_vector_select;
  } tcr_ctrl_t;

  typedef struct packed {
    logic [7:0] bus_clock_divider;
    logic [7:0] core_clock_divider;
    logic [11:0] feedback_multiplier;
    logic [3:0] reference_divider;
  } tcr_pll_t;

  typedef logic [8:0] tcr_sync_t;

  typedef struct packed {
    tcr_ctrl_t ctrl;
    tcr_pll_t pll;
    logic unlocked;
    logic [15:0] lock_low;
    logic cfg_update;
    logic pll_update;
    tcr_sync_t s1;
    tcr_sync_t s2;
    tcr_sync_t s3;
    tcr_sync_t filt;
  } tcr_regs_state_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic rd_wait;
    logic wr_pend;
    logic [31:0] wr_addr;
  } tcr_slave_state_t;

endpackage

// File: logic/tcr_ahb_slave.sv
`timescale 1ns/1ps
module tcr_ahb_slave
  import tcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  tcr_bus_if.slave bus
);
  tcr_slave_state_t st, st_next;
  logic take;

  // Only word transfers are expected; hsize is not checked
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = !st.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign bus.wr = st.wr_pend;
  assign bus.wr_addr = st.wr_addr;
  assign bus.wdata = hwdata;

  always_comb begin
    st_next = st;
    bus.rd_addr = st.wr_addr;
    st_next.wr_pend = take && hwrite;
    if (take) begin
      st_next.wr_addr = haddr;
    end
    // One wait state on reads so a write just before is already visible
    st_next.rd_wait = take && !hwrite;
    if (st.rd_wait) begin
      st_next.hrdata = bus.rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end
endmodule

// File: logic/tcr_regs.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "tcr_consts.svh"
// Contract
// - Control word writes drive chip configuration inputs only while unlocked
// - Control bits 31:13 ignore writes, read zero
// - Bits 12:11 pick test clock, reset 10
// - Bit 10 powers off PLL VCO
// - Bit 9 bypasses PLL with reference clock
// - Bits 8:3 active-low resets, reset high
// - Bit 2 unmaskable FIQ, bit 1 disable
// - Bit 0 selects high exception vectors
// - Status word shows PLD fields, 31:8 zero
// - Status bit 5 shows idle standby
// - Status bit 4 shows both PLLs locked
// - Status bits 3:0 give build identifier
// - PLL word bits 31:24 bus divider
// - PLL word bits 23:16 core divider
// - Feedback multiplier 15:4, reference divider 3:0
// - Identification bits 31:24 give processor type
// - Bits 17:15 give data cache size
// - Bits 14:12 instruction cache size, rest zero
module tcr_regs
  import tcr_pkg::*;
#(
  parameter logic [7:0] PROC_TYPE_CODE = 8'h5A,  // Arbitrary value
  parameter logic [2:0] DATA_CACHE_CODE = `TCR_CACHE_32K,
  parameter logic [2:0] INSTR_CACHE_CODE = `TCR_CACHE_32K
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [1:0] clock_test_select,
  output logic pll_vco_power_off,
  output logic pll_bypass_ctl,
  output logic vector_unit_reset_n,
  output logic nondebug_reset_n,
  output logic bus_if_reset_n,
  output logic pll_hard_reset_n,
  output logic trace_trigger_reset_n,
  output logic debug_bus_reset_n,
  output logic fast_irq_unmaskable_cfg,
  output logic syscop_disable,
  output logic high_vector_select,
  output logic cfg_update,
  output logic [7:0] bus_clock_divider,
  output logic [7:0] core_clock_divider,
  output logic [11:0] feedback_multiplier,
  output logic [3:0] reference_divider,
  output logic pll_update,
  input wire logic comms_receive_flag,
  input wire logic comms_transmit_flag,
  input wire logic idle_standby_flag,
  input wire logic chip_pll_locked,
  input wire logic board_pll_locked,
  input wire logic [3:0] logic_build_id
);
  tcr_bus_if bus ();
  tcr_regs_state_t st, st_next;
  tcr_sync_t raw_in;
  tcr_sync_t filt_next;
  logic [`TCR_STAT_W-1:0] status_word;
  logic [31:0] id_word;
  logic wr_ctrl;
  logic wr_pll;
  logic wr_lock;

  tcr_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus(bus.slave)
  );

  // Pins from the configuration logic run on their own timing
  assign raw_in = {logic_build_id, board_pll_locked, chip_pll_locked,
                   idle_standby_flag, comms_transmit_flag, comms_receive_flag};

  // A level counts only once stages two and three agree, rejecting one-cycle glitches
  for (genvar i = 0; i < `TCR_SYNC_W; i++) begin : g_filt
    assign filt_next[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.filt[i];
  end

  assign status_word = {st.filt[0],
                        st.filt[1],
                        st.filt[2],
                        st.filt[3] && st.filt[4],
                        st.filt[8:5]};

  assign id_word = {PROC_TYPE_CODE,
                    6'h00,
                    DATA_CACHE_CODE,
                    INSTR_CACHE_CODE,
                    12'h000};

  assign wr_ctrl = bus.wr && (bus.wr_addr == `TCR_CTRL_OFS);
  assign wr_pll = bus.wr && (bus.wr_addr == `TCR_PLL_OFS);
  assign wr_lock = bus.wr && (bus.wr_addr == `TCR_LOCK_OFS);

  always_comb begin
    st_next = st;
    st_next.s1 = raw_in;
    st_next.s2 = st.s1;
    st_next.s3 = st.s2;
    st_next.filt = filt_next;
    st_next.cfg_update = 1'b0;
    st_next.pll_update = 1'b0;
    if (wr_lock) begin
      // Any value other than the key relocks
      st_next.unlocked = (bus.wdata == `TCR_UNLOCK_KEY);
      st_next.lock_low = bus.wdata[15:0];
    end
    if (wr_ctrl && st.unlocked) begin
      st_next.ctrl = tcr_ctrl_t'(bus.wdata[`TCR_CTRL_W-1:0]);
      st_next.cfg_update = 1'b1;
    end
    if (wr_pll && st.unlocked) begin
      st_next.pll = tcr_pll_t'(bus.wdata);
      st_next.pll_update = 1'b1;
    end
  end

  always_comb begin
    unique case (bus.rd_addr)
      `TCR_CTRL_OFS: bus.rdata = {19'h0_0000, st.ctrl};
      `TCR_STAT_OFS: bus.rdata = {24'h00_0000, status_word};
      `TCR_PLL_OFS: bus.rdata = st.pll;
      `TCR_ID_OFS: bus.rdata = id_word;
      `TCR_LOCK_OFS: bus.rdata = {15'h0000, !st.unlocked, st.lock_low};
      default: bus.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.ctrl <= tcr_ctrl_t'(`TCR_CTRL_RESET);
      st.pll <= tcr_pll_t'(`TCR_PLL_RESET);
    end else begin
      st <= st_next;
    end
  end

  // Field to pin map; reset levels come from the control reset constant
  assign clock_test_select = st.ctrl.clock_test_select;
  assign pll_vco_power_off = st.ctrl.pll_vco_power_off;
  assign pll_bypass_ctl = st.ctrl.pll_bypass_ctl;
  assign vector_unit_reset_n = st.ctrl.vector_unit_reset_n;
  assign nondebug_reset_n = st.ctrl.nondebug_reset_n;
  assign bus_if_reset_n = st.ctrl.bus_if_reset_n;
  assign pll_hard_reset_n = st.ctrl.pll_hard_reset_n;
  assign trace_trigger_reset_n = st.ctrl.trace_trigger_reset_n;
  assign debug_bus_reset_n = st.ctrl.debug_bus_reset_n;
  // Chip samples these three only in its own reset
  assign fast_irq_unmaskable_cfg = st.ctrl.fast_irq_unmaskable_cfg;
  assign syscop_disable = st.ctrl.syscop_disable;
  assign high_vector_select = st.ctrl.high_vector_select;
  assign cfg_update = st.cfg_update;
  assign bus_clock_divider = st.pll.bus_clock_divider;
  assign core_clock_divider = st.pll.core_clock_divider;
  assign feedback_multiplier = st.pll.feedback_multiplier;
  assign reference_divider = st.pll.reference_divider;
  assign pll_update = st.pll_update;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence ctrl_write_s;
    wr_ctrl && st.unlocked;
  endsequence

  sequence lock_held_s;
    (chip_pll_locked && board_pll_locked)[*6];
  endsequence

  sequence idle_held_s;
    idle_standby_flag[*6];
  endsequence

  ctrl_high_zero_a: assert property (
    bus.rd_addr == `TCR_CTRL_OFS |-> bus.rdata[31:13] == 19'h0_0000)
    else $error("control word upper bits not zero");

  ctrl_write_a: assert property (
    ctrl_write_s |=> cfg_update
      && clock_test_select == $past(bus.wdata[12:11])
      && high_vector_select == $past(bus.wdata[0])
      && vector_unit_reset_n == $past(bus.wdata[8]))
    else $error("control write not forwarded to pins");

  locked_ctrl_a: assert property (
    wr_ctrl && !st.unlocked |=> $stable(st.ctrl) && !cfg_update)
    else $error("locked control word changed");

  locked_pll_a: assert property (
    wr_pll && !st.unlocked |=> $stable(st.pll) && !pll_update)
    else $error("locked pll word changed");

  pll_write_a: assert property (
    wr_pll && st.unlocked |=> pll_update
      && {bus_clock_divider, core_clock_divider, feedback_multiplier,
          reference_divider} == $past(bus.wdata))
    else $error("pll word not loaded");

  unlock_key_a: assert property (
    wr_lock |=> st.unlocked == ($past(bus.wdata) == `TCR_UNLOCK_KEY))
    else $error("unlock state wrong after lock write");

  status_high_a: assert property (
    bus.rd_addr == `TCR_STAT_OFS |-> bus.rdata[31:8] == 24'h00_0000)
    else $error("status upper bits not zero");

  pll_lock_a: assert property (
    lock_held_s |-> status_word[4])
    else $error("pll lock not reported");

  idle_flag_a: assert property (
    idle_held_s |-> status_word[5])
    else $error("idle standby not reported");

  id_word_a: assert property (
    bus.rd_addr == `TCR_ID_OFS |-> bus.rdata[31:24] == PROC_TYPE_CODE
      && bus.rdata[23:18] == 6'h00 && bus.rdata[11:0] == 12'h000
      && bus.rdata[17:15] == DATA_CACHE_CODE && bus.rdata[14:12] == INSTR_CACHE_CODE)
    else $error("identification word wrong");

  build_id_a: assert property (
    $stable(logic_build_id)[*6] |-> status_word[3:0] == logic_build_id)
    else $error("build identifier not reported");

  read_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  sequence pll_write_s;
    wr_pll && st.unlocked;
  endsequence

  sequence read_take_s;
    hsel && htrans[1] && hready && !hwrite;
  endsequence

  // One-cycle blip between quiet stretches; the agreement filter must swallow it
  sequence idle_blip_s;
    (!idle_standby_flag)[*3] ##1 idle_standby_flag ##1 (!idle_standby_flag)[*6];
  endsequence

  reset_values_a: assert property (
    $rose(hresetn) |-> st.ctrl == tcr_ctrl_t'(`TCR_CTRL_RESET)
      && st.pll == tcr_pll_t'(`TCR_PLL_RESET) && !st.unlocked)
    else $error("reset values wrong after release");

  ctrl_pins_a: assert property (
    ctrl_write_s |=> {clock_test_select, pll_vco_power_off, pll_bypass_ctl,
      vector_unit_reset_n, nondebug_reset_n, bus_if_reset_n, pll_hard_reset_n,
      trace_trigger_reset_n, debug_bus_reset_n, fast_irq_unmaskable_cfg,
      syscop_disable, high_vector_select} == $past(bus.wdata[12:0]))
    else $error("control pins differ from written word");

  ctrl_hold_a: assert property (
    !(wr_ctrl && st.unlocked) |=> $stable(st.ctrl))
    else $error("control word changed without a write");

  pll_hold_a: assert property (
    !(wr_pll && st.unlocked) |=> $stable(st.pll))
    else $error("pll word changed without a write");

  cfg_pulse_a: assert property (
    cfg_update |-> $past(wr_ctrl && st.unlocked))
    else $error("control pulse without a write");

  pll_pulse_a: assert property (
    pll_update |-> $past(wr_pll && st.unlocked))
    else $error("pll pulse without a write");

  pll_fields_a: assert property (
    pll_write_s |=> core_clock_divider == $past(bus.wdata[23:16])
      && reference_divider == $past(bus.wdata[3:0]))
    else $error("pll fields not loaded");

  lock_hold_a: assert property (
    !wr_lock |=> $stable(st.unlocked))
    else $error("lock state changed without a lock write");

  ctrl_read_a: assert property (
    bus.rd_addr == `TCR_CTRL_OFS |-> bus.rdata[12:0] == {clock_test_select,
      pll_vco_power_off, pll_bypass_ctl, vector_unit_reset_n, nondebug_reset_n,
      bus_if_reset_n, pll_hard_reset_n, trace_trigger_reset_n, debug_bus_reset_n,
      fast_irq_unmaskable_cfg, syscop_disable, high_vector_select})
    else $error("control read differs from pins");

  pll_read_a: assert property (
    bus.rd_addr == `TCR_PLL_OFS |-> bus.rdata == {bus_clock_divider,
      core_clock_divider, feedback_multiplier, reference_divider})
    else $error("pll read differs from pins");

  hole_read_a: assert property (
    !(bus.rd_addr inside {`TCR_CTRL_OFS, `TCR_STAT_OFS, `TCR_PLL_OFS, `TCR_ID_OFS,
      `TCR_LOCK_OFS}) |-> bus.rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  comms_rx_a: assert property (
    comms_receive_flag[*6] |-> status_word[7])
    else $error("receive flag not reported");

  comms_tx_a: assert property (
    comms_transmit_flag[*6] |-> status_word[6])
    else $error("transmit flag not reported");

  idle_low_a: assert property (
    (!idle_standby_flag)[*6] |-> !status_word[5])
    else $error("idle standby stuck high");

  idle_blip_a: assert property (
    idle_blip_s |-> !status_word[5])
    else $error("one-cycle idle blip reached status");

  pll_unlock_a: assert property (
    (!chip_pll_locked)[*6] |-> !status_word[4])
    else $error("pll lock stuck high");

  write_ready_a: assert property (
    hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase not ready");

  read_data_a: assert property (
    read_take_s |-> ##2 hrdata == $past(bus.rdata))
    else $error("read data not returned");
endmodule
